// ---- include/scope_acq_defs.vh ----
`ifndef SCOPE_ACQ_DEFS_VH
`define SCOPE_ACQ_DEFS_VH

`define CTRL_OFF      8'h00
`define CHEN_OFF      8'h04
`define TB_OFF        8'h08
`define STAT_OFF      8'h0c
`define RLEN_OFF      8'h10
`define SINT_OFF      8'h14
`define OP_OFF        8'h18
`define MADDR_OFF     8'h1c
`define MDATA_OFF     8'h20

`define CTRL_MODE_LSB 0
`define CTRL_RUN_BIT  2
`define CTRL_FOUR_BIT 3
`define CTRL_EXT_BIT  4
`define CTRL_MAX_BIT  5
`define CTRL_PEAK_BIT 6
`define CTRL_ENV_BIT  7
`define CTRL_TV_BIT   8
`define CTRL_RST      9'h008
`define CHEN_RST      4'h1
`define TB_RST        32'h000001f4

`define MODE_RECUR    2'h0
`define MODE_SINGLE   2'h1
`define MODE_ROLL     2'h2

`define OP_CLEAR      2'h1
`define OP_SAVE       2'h2
`define OP_COPY       2'h3
`define OP_SRC_LSB    4
`define OP_DST_LSB    8

`define REC_NORMAL    16'h0200
`define REC_2K        16'h0800
`define REC_4K        16'h1000
`define REC_8K        16'h2000
`define REC_16K       16'h4000
`define REC_32K       16'h8000

`define ACQ_BYTES     17'h08000
`define MEM_AW        15
`define TRACE_BASE    15'h4000
`define TRACE_WORDS   11'h400
`define DIVS_PER_SCREEN 8'h0a
`define MIN_SAMPLE_NS 32'h00000005
`define ALT_TB_NS     32'h000000fa
`define SAMPLE_BITS   8

`endif

// ---- verilog/trace_mem.v ----
`timescale 1ns/1ps
`default_nettype none
`include "scope_acq_defs.vh"
module trace_mem (
    input  wire                 aclk,
    input  wire [`MEM_AW-1:0]   a_addr,
    input  wire                 a_we,
    input  wire [15:0]          a_wdata,
    output reg  [15:0]          a_rdata,
    input  wire [`MEM_AW-1:0]   b_addr,
    output reg  [15:0]          b_rdata
);
    reg [15:0] mem [0:(1<<`MEM_AW)-1];

    always @(posedge aclk) begin
        if (a_we) begin
            mem[a_addr] <= a_wdata;
        end
        a_rdata <= mem[a_addr];
        b_rdata <= mem[b_addr];
    end
endmodule
`default_nettype wire

// ---- verilog/scope_acq.v ----
// The register offsets and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "scope_acq_defs.vh"
module scope_acq (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire [`SAMPLE_BITS-1:0] adc_a,
    input  wire [`SAMPLE_BITS-1:0] adc_b,
    input  wire        adc_valid,
    input  wire        trig_in,
    output reg         mux_sel,
    output reg         mux_ext,
    output reg  [31:0] sample_interval_ns,
    output reg         acq_active
);
    localparam S_IDLE = 2'd0;
    localparam S_ARM  = 2'd1;
    localparam S_FILL = 2'd2;
    localparam S_DONE = 2'd3;
    localparam O_IDLE = 2'd0;
    localparam O_RD   = 2'd1;
    localparam O_WR   = 2'd2;

    reg [8:0]  ctrl;
    reg [3:0]  chen;
    reg [31:0] timebase_ns;
    reg [11:0] op_reg;
    reg [14:0] mem_addr_sw;
    reg [1:0]  state;
    reg [1:0]  ostate;
    reg [14:0] wptr;
    reg [10:0] ocnt;
    reg        op_err;
    reg        chop_phase;
    reg        aw_full;
    reg        w_full;
    reg [7:0]  aw_addr;
    reg [31:0] w_data;
    reg [3:0]  w_strb;

    wire [1:0]  mode = ctrl[`CTRL_MODE_LSB+1:`CTRL_MODE_LSB];
    wire        four = ctrl[`CTRL_FOUR_BIT];
    wire        tv   = ctrl[`CTRL_TV_BIT];
    wire        pe   = ctrl[`CTRL_PEAK_BIT] | ctrl[`CTRL_ENV_BIT];

    // Record length per channel from variant, length choice and channel count.
    function [15:0] rec_len;
        input       fv;
        input       ext;
        input       mx;
        input       pk;
        input       trv;
        input [2:0] n;
        reg   [15:0] r;
        begin
            r = `REC_NORMAL;
            if (mx) begin
                if (fv) begin
                    r = (n >= 3'd3) ? `REC_8K : ((n == 3'd2) ? `REC_16K : `REC_32K);
                end else if (ext) begin
                    r = trv ? `REC_8K : ((n >= 3'd2) ? `REC_16K : `REC_32K);
                end else begin
                    r = trv ? `REC_2K : ((n >= 3'd2) ? `REC_4K : `REC_8K);
                end
                if (pk) begin
                    r = r >> 1;
                end
            end
            rec_len = r;
        end
    endfunction

    function [4:0] log2_16;
        input [15:0] v;
        integer i;
        begin
            log2_16 = 5'd0;
            for (i = 0; i < 16; i = i + 1) begin
                if (v[i]) begin
                    log2_16 = i[4:0];
                end
            end
        end
    endfunction

    // Slot 0 is the live acquisition record, slots 1 to 15 are trace registers.
    function [14:0] slot_base;
        input [3:0] n;
        begin
            if (n == 4'h0) begin
                slot_base = 15'h0000;
            end else begin
                slot_base = `TRACE_BASE + {1'b0, n - 4'h1, 10'h000};
            end
        end
    endfunction

    wire [2:0] nch_raw = four ? ({2'b00, chen[0]} + {2'b00, chen[1]}
                                 + {2'b00, chen[2]} + {2'b00, chen[3]})
                              : ({2'b00, chen[0]} + {2'b00, chen[1]});
    wire [2:0] nch     = (nch_raw == 3'd0) ? 3'd1 : nch_raw;
    wire [15:0] rlen   = rec_len(four, ctrl[`CTRL_EXT_BIT], ctrl[`CTRL_MAX_BIT], pe, tv, nch);
    // Trigger view takes a record of its own in the shared memory on the two-input variant.
    wire [2:0] nstore  = (!four && tv) ? nch + 3'd1 : nch;
    wire [18:0] bytes_raw = {3'b000, rlen} * {16'h0000, nstore};
    wire [16:0] bytes  = (bytes_raw > {2'b00, `ACQ_BYTES}) ? `ACQ_BYTES : bytes_raw[16:0];
    wire [14:0] words  = bytes[15:1] + {14'h0000, bytes[16]};
    wire [14:0] last_w = words - 15'h0001;

    wire need_a = chen[0] | chen[1];
    wire need_b = four ? (chen[2] | chen[3] | tv) : tv;
    wire both   = need_a & need_b;
    wire alt    = pe | (timebase_ns >= `ALT_TB_NS);

    wire [39:0] tb_x10 = {8'h00, timebase_ns} * {32'h0, `DIVS_PER_SCREEN};
    wire [39:0] tb_per = tb_x10 >> log2_16(rlen);

    always @(posedge aclk) begin
        if (!aresetn) begin
            sample_interval_ns <= `MIN_SAMPLE_NS;
        end else if (tb_per[39:32] != 8'h00) begin
            sample_interval_ns <= 32'hffffffff;
        end else if (tb_per[31:0] < `MIN_SAMPLE_NS) begin
            sample_interval_ns <= `MIN_SAMPLE_NS;
        end else begin
            sample_interval_ns <= tb_per[31:0];
        end
    end

    // Multiplexer control: chopped swaps pairs every sample, alternated swaps at half record.
    always @(posedge aclk) begin
        if (!aresetn) begin
            mux_sel <= 1'b0;
            mux_ext <= 1'b0;
        end else begin
            mux_ext <= tv;
            if (!both) begin
                mux_sel <= need_b & ~need_a;
            end else if (alt) begin
                mux_sel <= (wptr >= {1'b0, words[14:1]});
            end else begin
                mux_sel <= chop_phase;
            end
        end
    end

    // AXI4-Lite write channel: address and data may arrive in either order.
    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take  = s_axi_wvalid & s_axi_wready;
    wire do_wr   = aw_full & w_full & ~s_axi_bvalid;
    assign s_axi_awready = ~aw_full;
    assign s_axi_wready  = ~w_full;
    assign s_axi_arready = ~s_axi_rvalid;

    wire wr_ctrl = do_wr && (aw_addr == `CTRL_OFF);
    wire wr_op   = do_wr && (aw_addr == `OP_OFF) && w_strb[0];
    wire wr_run  = wr_ctrl && w_strb[0] && w_data[`CTRL_RUN_BIT];
    wire acq_busy = (state == S_ARM) || (state == S_FILL);
    wire op_start = wr_op && (w_data[1:0] != 2'b00) && (ostate == O_IDLE) && !acq_busy;

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_full      <= 1'b0;
            w_full       <= 1'b0;
            aw_addr      <= 8'h00;
            w_data       <= 32'h0;
            w_strb       <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'b00;
        end else begin
            if (aw_take) begin
                aw_full <= 1'b1;
                aw_addr <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (w_take) begin
                w_full <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_wr) begin
                aw_full      <= 1'b0;
                w_full       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (aw_addr == `CTRL_OFF || aw_addr == `CHEN_OFF || aw_addr == `TB_OFF
                    || aw_addr == `OP_OFF || aw_addr == `MADDR_OFF) begin
                    s_axi_bresp <= 2'b00;
                end else begin
                    s_axi_bresp <= 2'b10;
                end
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Software registers; the run bit is also cleared by hardware after a single shot.
    always @(posedge aclk) begin
        if (!aresetn) begin
            ctrl        <= `CTRL_RST;
            chen        <= `CHEN_RST;
            timebase_ns <= `TB_RST;
            op_reg      <= 12'h000;
            mem_addr_sw <= 15'h0000;
        end else begin
            if (state == S_FILL && adc_valid && wptr == last_w && mode == `MODE_SINGLE) begin
                ctrl[`CTRL_RUN_BIT] <= 1'b0;
            end
            if (wr_ctrl) begin
                if (w_strb[0]) begin
                    ctrl[7:0] <= w_data[7:0];
                    if (w_data[1:0] == 2'b11) begin
                        ctrl[1:0] <= `MODE_RECUR;
                    end
                end
                if (w_strb[1]) begin
                    ctrl[8] <= w_data[8];
                end
            end
            if (do_wr && aw_addr == `CHEN_OFF && w_strb[0]) begin
                chen <= w_data[3:0];
            end
            if (do_wr && aw_addr == `TB_OFF) begin
                if (w_strb[0]) timebase_ns[7:0]   <= w_data[7:0];
                if (w_strb[1]) timebase_ns[15:8]  <= w_data[15:8];
                if (w_strb[2]) timebase_ns[23:16] <= w_data[23:16];
                if (w_strb[3]) timebase_ns[31:24] <= w_data[31:24];
            end
            if (op_start) begin
                op_reg <= w_data[11:0];
            end
            if (do_wr && aw_addr == `MADDR_OFF) begin
                mem_addr_sw <= w_data[14:0];
            end
        end
    end

    // Acquisition sequencer.
    always @(posedge aclk) begin
        if (!aresetn) begin
            state      <= S_IDLE;
            wptr       <= 15'h0000;
            chop_phase <= 1'b0;
            acq_active <= 1'b0;
        end else begin
            acq_active <= (state == S_FILL);
            case (state)
                S_IDLE, S_DONE: begin
                    wptr       <= 15'h0000;
                    chop_phase <= 1'b0;
                    if (wr_run && ostate == O_IDLE) begin
                        state <= (w_data[1:0] == `MODE_ROLL) ? S_FILL : S_ARM;
                    end
                end
                S_ARM: begin
                    if (!ctrl[`CTRL_RUN_BIT]) begin
                        state <= S_IDLE;
                    end else if (trig_in) begin
                        state <= S_FILL;
                    end
                end
                S_FILL: begin
                    if (!ctrl[`CTRL_RUN_BIT]) begin
                        state <= S_IDLE;
                    end else if (adc_valid) begin
                        chop_phase <= both ? ~chop_phase : 1'b0;
                        if (wptr == last_w) begin
                            wptr       <= 15'h0000;
                            chop_phase <= 1'b0;
                            if (mode == `MODE_SINGLE) begin
                                state <= S_DONE;
                            end else if (mode == `MODE_RECUR) begin
                                state <= S_ARM;
                            end
                        end else begin
                            wptr <= wptr + 15'h0001;
                        end
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    // Trace register operations run one word per cycle for clear, two for save and copy.
    always @(posedge aclk) begin
        if (!aresetn) begin
            ostate <= O_IDLE;
            ocnt   <= 11'h000;
            op_err <= 1'b0;
        end else begin
            if (wr_op && !op_start && w_data[1:0] != 2'b00) begin
                op_err <= 1'b1;
            end else if (op_start) begin
                op_err <= 1'b0;
            end
            case (ostate)
                O_IDLE: begin
                    ocnt <= 11'h000;
                    if (op_start) begin
                        ostate <= (w_data[1:0] == `OP_CLEAR) ? O_WR : O_RD;
                    end
                end
                O_RD: ostate <= O_WR;
                O_WR: begin
                    if (ocnt == `TRACE_WORDS - 11'h001) begin
                        ostate <= O_IDLE;
                    end else begin
                        ocnt   <= ocnt + 11'h001;
                        ostate <= (op_reg[1:0] == `OP_CLEAR) ? O_WR : O_RD;
                    end
                end
                default: ostate <= O_IDLE;
            endcase
        end
    end

    wire [3:0]  src_slot = (op_reg[1:0] == `OP_SAVE) ? 4'h0 : op_reg[`OP_SRC_LSB+3:`OP_SRC_LSB];
    wire [3:0]  dst_slot = op_reg[`OP_DST_LSB+3:`OP_DST_LSB];
    wire [14:0] ooff     = {5'h00, ocnt[9:0]};
    wire [15:0] mem_rd;
    wire [15:0] mem_sw_rd;
    reg  [14:0] mem_addr;
    reg         mem_we;
    reg  [15:0] mem_wd;

    always @* begin
        mem_addr = wptr;
        mem_we   = 1'b0;
        mem_wd   = {adc_b, adc_a};
        if (ostate == O_RD) begin
            mem_addr = slot_base(src_slot) + ooff;
        end else if (ostate == O_WR) begin
            mem_addr = slot_base(dst_slot) + ooff;
            mem_we   = 1'b1;
            mem_wd   = (op_reg[1:0] == `OP_CLEAR) ? 16'h0000 : mem_rd;
        end else if (state == S_FILL && adc_valid && ctrl[`CTRL_RUN_BIT]) begin
            mem_we = 1'b1;
        end
    end

    trace_mem u_mem (
        .aclk    (aclk),
        .a_addr  (mem_addr),
        .a_we    (mem_we),
        .a_wdata (mem_wd),
        .a_rdata (mem_rd),
        .b_addr  (mem_addr_sw),
        .b_rdata (mem_sw_rd)
    );

    // AXI4-Lite read channel; the memory window shows the word at the address held in the memory address register.
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= 2'b00;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'b00;
            if (s_axi_araddr[7:2] == `CTRL_OFF >> 2) begin
                s_axi_rdata <= {23'h0, ctrl};
            end else if (s_axi_araddr[7:2] == `CHEN_OFF >> 2) begin
                s_axi_rdata <= {28'h0, chen};
            end else if (s_axi_araddr[7:2] == `TB_OFF >> 2) begin
                s_axi_rdata <= timebase_ns;
            end else if (s_axi_araddr[7:2] == `STAT_OFF >> 2) begin
                s_axi_rdata <= {24'h0, op_err, ostate != O_IDLE, mux_sel, alt,
                                state == S_DONE, acq_busy, state};
            end else if (s_axi_araddr[7:2] == `RLEN_OFF >> 2) begin
                s_axi_rdata <= {1'b0, words, rlen};
            end else if (s_axi_araddr[7:2] == `SINT_OFF >> 2) begin
                s_axi_rdata <= sample_interval_ns;
            end else if (s_axi_araddr[7:2] == `OP_OFF >> 2) begin
                s_axi_rdata <= {20'h0, op_reg};
            end else if (s_axi_araddr[7:2] == `MADDR_OFF >> 2) begin
                s_axi_rdata <= {17'h0, mem_addr_sw};
            end else if (s_axi_araddr[7:2] == `MDATA_OFF >> 2) begin
                s_axi_rdata <= {16'h0, mem_sw_rd};
            end else begin
                s_axi_rdata <= 32'h0;
                s_axi_rresp <= 2'b10;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ---- testbench/scope_acq_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module scope_acq_props (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        mux_sel,
    input wire logic [31:0] sample_interval_ns,
    input wire logic        acq_active
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    // The reset check keeps its own disable, otherwise it could never be evaluated.
    reset_quiet_a: assert property (disable iff (1'b0)
        !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !acq_active && !mux_sel
        && sample_interval_ns == 32'h5) else $error("outputs not idle after reset");
    interval_floor_a: assert property (sample_interval_ns >= 32'h5)
        else $error("sample interval below floor");
    write_answer_a: assert property (wr_taken |-> ##2 s_axi_bvalid)
        else $error("write response late");
    read_answer_a: assert property (rd_taken |=> s_axi_rvalid)
        else $error("read data late");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    bvalid_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    rvalid_drop_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data repeated");
    arready_tie_a: assert property (s_axi_arready == !s_axi_rvalid)
        else $error("read address ready wrong");
endmodule
bind scope_acq scope_acq_props i_scope_acq_props (.*);
`default_nettype wire

// ---- testbench/digitizer_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module digitizer_model (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       slow,
    output logic      [7:0] adc_a,
    output logic      [7:0] adc_b,
    output logic            adc_valid
);
    logic [7:0] cnt;
    logic [1:0] gap;
    always @(posedge aclk) begin
        if (!aresetn) begin
            cnt <= 8'h00;
            gap <= 2'h0;
            adc_valid <= 1'b0;
        end else begin
            gap <= slow ? gap + 2'h1 : 2'h0;
            adc_valid <= !slow || gap == 2'h3;
            if (adc_valid)
                cnt <= cnt + 8'h01;
        end
    end
    // Off strobe the lines carry the inverse, so a capture at the wrong cycle shows.
    assign adc_a = adc_valid ? cnt : ~cnt;
    assign adc_b = adc_valid ? ~cnt : cnt;
endmodule
`default_nettype wire

// ---- testbench/tb_scope_acq.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "scope_acq_defs.vh"
module tb_scope_acq;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00;
    logic [7:0]  s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    logic        trig_in = 1'b0;
    logic        slow = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic [31:0] s_axi_rdata, sample_interval_ns, q, t, x, cfg;
    logic [7:0]  adc_a, adc_b, y;
    logic        adc_valid, mux_sel, mux_ext, acq_active;
    logic        hi = 1'b0;
    logic        prev = 1'b0;
    logic [8:0]  c;
    logic [3:0]  e;
    logic [15:0] seed = 16'h1653;
    logic [7:0]  ra [7] = '{`CTRL_OFF, `CHEN_OFF, `TB_OFF, `OP_OFF, `MADDR_OFF, `RLEN_OFF, `SINT_OFF};
    logic [31:0] rv [7] = '{32'h8, 32'h1, 32'h1f4, 32'h0, 32'h0, 32'h01000200, 32'h9};
    logic [8:0]  ck [4] = '{9'h028, 9'h070, 9'h008, 9'h008};
    logic [3:0]  ek [4] = '{4'hf, 4'h1, 4'h5, 4'h5};
    logic [31:0] tk [4] = '{32'h1, 32'h7d0, 32'hfa, 32'hf9};
    int          rises = 0;
    int          n_errors = 0;
    int          checked = 0;

    always #5 aclk = ~aclk;

    scope_acq i_scope_acq (.*);
    digitizer_model i_digitizer_model (.*);

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    function automatic void chk(input string nm, input logic [31:0] ex, input logic [31:0] sn);
        checked++;
        if (sn !== ex) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, ex, sn);
        end
    endfunction

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    function automatic logic [31:0] exp_rlen(input logic [8:0] cf, input logic [3:0] en);
        int n;
        logic [31:0] v;
        n = cf[3] ? $countones(en) : $countones(en[1:0]);
        n = n == 0 ? 1 : n;
        if (!cf[5])
            v = 32'h200;
        else if (cf[3])
            v = n > 2 ? 32'h2000 : n == 2 ? 32'h4000 : 32'h8000;
        else if (cf[8])
            v = cf[4] ? 32'h2000 : 32'h800;
        else
            v = (n == 2 ? 32'h1000 : 32'h2000) << (cf[4] ? 2 : 0);
        if (cf[5] && (cf[6] || cf[7]))
            v = v >> 1;
        n = v * (n + int'(!cf[3] && cf[8]));
        return {1'b0, 15'((n > 32768 ? 32768 : n) / 2), v[15:0]};
    endfunction

    function automatic logic [31:0] exp_sint(input logic [31:0] tb, input logic [31:0] rl);
        logic [31:0] v;
        v = (tb * 32'ha) >> $clog2(rl[15:0]);
        return v < 32'h5 ? 32'h5 : v;
    endfunction

    // Starts right after a rising edge; ready and answer are taken at the rising edge.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, tr, ans, fin;
        if (w) begin
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
        end else begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
        end
        for (int i = 0; i < 100; i++) begin
            @(posedge aclk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tr = s_axi_arvalid && s_axi_arready;
            ans = w ? s_axi_bvalid : s_axi_rvalid;
            fin = ans && (w ? s_axi_bready : s_axi_rready);
            q = s_axi_rdata;
            r = w ? s_axi_bresp : s_axi_rresp;
            if (ta)
                s_axi_awvalid <= 1'b0;
            if (tw)
                s_axi_wvalid <= 1'b0;
            if (tr)
                s_axi_arvalid <= 1'b0;
            if (fin) begin
                s_axi_bready <= 1'b0;
                s_axi_rready <= 1'b0;
                return;
            end
            if (ans && w)
                s_axi_bready <= 1'b1;
            if (ans && !w)
                s_axi_rready <= 1'b1;
        end
        chk("bus answer", 32'h1, 32'h0);
        report_and_stop();
    endtask

    task automatic poll(input logic [31:0] m, input logic [31:0] v);
        for (int i = 0; i < 3000; i++) begin
            xfer(1'b0, `STAT_OFF, 32'h0);
            if ((q & m) === v)
                return;
        end
        chk("status wait", v, q & m);
        report_and_stop();
    endtask

    task automatic peek(input logic [14:0] a);
        xfer(1'b1, `MADDR_OFF, {17'h0, a});
        xfer(1'b0, `MDATA_OFF, 32'h0);
    endtask

    task automatic op(input logic [31:0] cmd);
        xfer(1'b1, `OP_OFF, cmd);
        poll(32'h40, 32'h0);
    endtask

    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        foreach (ra[k]) begin
            xfer(1'b0, ra[k], 32'h0);
            chk("reset value", rv[k], q);
        end
        xfer(1'b1, 8'h40, 32'hffffffff);
        chk("unmapped write", 32'h2, {30'h0, r});
        xfer(1'b0, 8'h40, 32'h0);
        chk("unmapped read", 32'h2, {30'h0, r} | q);
        $display("reset and map test done");
        for (int k = 0; k < 24; k++) begin
            seed = lfsr(lfsr(seed));
            cfg = {seed, lfsr(seed)};
            c = k < 4 ? ck[k] : {cfg[8:3], 3'h0};
            e = k < 4 ? ek[k] : cfg[12:9];
            t = k < 4 ? tk[k] : {22'h0, cfg[25:16]} + 32'h1;
            if (!c[3] && c[8])
                e = 4'h3;
            xfer(1'b1, `CTRL_OFF, {23'h0, c});
            xfer(1'b1, `CHEN_OFF, {28'h0, e});
            xfer(1'b1, `TB_OFF, t);
            xfer(1'b0, `RLEN_OFF, 32'h0);
            chk("record length", exp_rlen(c, e), q);
            x = exp_sint(t, exp_rlen(c, e));
            xfer(1'b0, `SINT_OFF, 32'h0);
            chk("sample interval", x, q);
            chk("interval pin", x, sample_interval_ns);
            chk("trigger view pin", {31'h0, c[8]}, {31'h0, mux_ext});
            xfer(1'b0, `STAT_OFF, 32'h0);
            if (c[3] && |e[1:0] && (|e[3:2] || c[8]))
                chk("alternated", {31'h0, c[6] || c[7] || t >= 32'hfa}, {31'h0, q[4]});
        end
        $display("record length test done");
        xfer(1'b1, `CHEN_OFF, 32'h5);
        xfer(1'b1, `TB_OFF, 32'h3e8);
        xfer(1'b1, `CTRL_OFF, 32'h00c);
        trig_in <= 1'b1;
        repeat (2000) begin
            @(negedge aclk);
            hi = hi | (acq_active & mux_sel);
            rises += int'(acq_active && !prev);
            prev = acq_active;
        end
        @(posedge aclk);
        chk("upper pair used", 32'h1, {31'h0, hi});
        chk("recurrent rearm", 32'h1, {31'h0, rises > 1});
        xfer(1'b1, `CTRL_OFF, 32'h008);
        trig_in <= 1'b0;
        poll(32'h4, 32'h0);
        $display("recurrent test done");
        xfer(1'b1, `CHEN_OFF, 32'h1);
        slow <= 1'b1;
        xfer(1'b1, `CTRL_OFF, 32'h00d);
        repeat (20) @(posedge aclk);
        xfer(1'b0, `STAT_OFF, 32'h0);
        chk("armed before trigger", 32'h1, {30'h0, q[1:0]});
        trig_in <= 1'b1;
        poll(32'h3, 32'h3);
        trig_in <= 1'b0;
        xfer(1'b0, `CTRL_OFF, 32'h0);
        chk("run cleared", 32'h0, {31'h0, q[2]});
        chk("stopped", 32'h0, {31'h0, acq_active});
        peek(15'h0005);
        cfg = q;
        chk("word layout", {16'h0, ~cfg[7:0], cfg[7:0]}, cfg);
        y = cfg[7:0] + 8'h01;
        peek(15'h0006);
        chk("next sample", {16'h0, ~y, y}, q);
        $display("single shot test done");
        op(32'h102);
        peek(15'h4005);
        chk("saved word", cfg, q);
        op(32'h213);
        peek(15'h4405);
        chk("copied word", cfg, q);
        op(32'h111);
        peek(15'h4005);
        chk("cleared word", 32'h0, q);
        peek(15'h43ff);
        chk("cleared last word", 32'h0, q);
        peek(15'h4405);
        chk("other slot kept", cfg, q);
        $display("trace operation test done");
        report_and_stop();
    end
endmodule
`default_nettype wire
